// ---- design/ecpp_core.sv ----
`timescale 1ns/10ps
`default_nettype none

module ecpp_core
(
    // System
    input wire logic clk_sys,
    input wire logic rst_n,
    // Host I/O bus
    input wire logic cs_n,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic [10:0] addr,
    input wire logic [7:0] host_din,
    output logic [7:0] host_dout,
    output logic host_doe_n,
    // Host interrupt lines, active low
    output logic irq5_n,
    output logic irq7_n,
    output logic irq9_n,
    // Host DMA channels
    output logic [3:1] dma_req,
    input wire logic [3:1] dma_ack_n,
    input wire logic term_count,
    // Peripheral data lines
    input wire logic [7:0] periph_data_lines_in,
    output logic [7:0] periph_data_lines_out,
    output logic periph_data_lines_oe_n,
    // Peripheral control outputs, active low
    output logic strobe_out_n,
    output logic line_feed_out_n,
    output logic init_out_n,
    output logic select_out_n,
    // Peripheral status inputs
    input wire logic fault_in_n,
    input wire logic selected_in,
    input wire logic busy_in,
    input wire logic accept_in_n,
    input wire logic media_absent_in,
    // Direction indicator
    output logic direction_indicator
);
    import ecpp_pkg::*;

    // Registers
    logic [7:0] data_r;
    logic [7:0] control_r;
    logic [7:0] ectrl_r;
    logic [5:0] chcfg_r;
    logic [7:0] pout_r;
    logic strobe_r;
    logic [7:0] scnt_r;
    logic dma_act_r;
    ecpp_mode_type mode;
    logic dir;
    logic drive_ok;
    logic wr_pulse;
    logic rd_act;
    logic hit_data, hit_ctl, hit_fifo, hit_chcfg, hit_ectrl;
    logic fifo_mode;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [8:0] f_out_data;
    logic [4:0] f_level;
    logic full_flag, empty_flag;
    logic svc_hit;
    logic ack_irq;
    logic irq_pulse_n;
    logic irq_line_n;

    assign mode = ecpp_mode_type'(ectrl_r[7:5]);
    assign fifo_mode = (mode == ECPP_MODE_CFIFO) || (mode == ECPP_MODE_EXT)
        || (mode == ECPP_MODE_TEST);

    ////////////////////////////////////////////////////////////////
    // Address decode; chip select gates everything
    assign hit_data = !cs_n && addr == ECPP_OFS_DATA;
    assign hit_ctl = !cs_n && addr == ECPP_OFS_CONTROL;
    assign hit_fifo = !cs_n && addr == ECPP_OFS_FIFO;
    assign hit_chcfg = !cs_n && addr == ECPP_OFS_CHCFG
        && mode == ECPP_MODE_CFG;
    assign hit_ectrl = !cs_n && addr == ECPP_OFS_ECTRL;
    assign rd_act = !cs_n && !ior_n;

    // Trailing edge of the write strobe commits the write
    ecpp_sync_edge u_wr_edge
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .strobe_n(iow_n),
        .rise(wr_pulse)
    );

    // Write data is held by the host until after the trailing edge;
    // the value last sampled while the strobe was low is used on the rise cycle
    logic [7:0] wdat_r;
    logic [10:0] wadr_r;
    logic wcs_r;

    // Capture address and data while the strobe is low
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wdat_r <= 8'h00;
            wadr_r <= 11'h000;
            wcs_r <= 1'b0;
        end
        else if (!iow_n)
        begin
            wdat_r <= host_din;
            wadr_r <= addr;
            wcs_r <= !cs_n;
        end
    end

    logic w_data, w_ctl, w_fifo, w_chcfg, w_ectrl;
    assign w_data = wr_pulse && wcs_r && wadr_r == ECPP_OFS_DATA;
    assign w_ctl = wr_pulse && wcs_r && wadr_r == ECPP_OFS_CONTROL;
    assign w_fifo = wr_pulse && wcs_r && wadr_r == ECPP_OFS_FIFO;
    assign w_chcfg = wr_pulse && wcs_r && wadr_r == ECPP_OFS_CHCFG
        && mode == ECPP_MODE_CFG;
    assign w_ectrl = wr_pulse && wcs_r && wadr_r == ECPP_OFS_ECTRL;

    ////////////////////////////////////////////////////////////////
    // Data register, only in modes 000/001
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            data_r <= 8'h00;
        else if (w_data && (mode == ECPP_MODE_STD || mode == ECPP_MODE_BIDIR))
            data_r <= wdat_r;
    end

    // Control register; direction written only in mode 001
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            control_r <= ECPP_CONTROL_RST;
        else if (w_ctl)
        begin
            control_r[4:0] <= wdat_r[4:0];
            if (mode == ECPP_MODE_BIDIR)
                control_r[ECPP_CTL_DIR] <= wdat_r[ECPP_CTL_DIR];
        end
    end

    // Extended control: mode field free only from 000/001
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            ectrl_r <= ECPP_ECTRL_RST;
        else
        begin
            if (w_ectrl)
            begin
                ectrl_r[4:3] <= wdat_r[4:3];
                ectrl_r[ECPP_ECR_SVC] <= wdat_r[ECPP_ECR_SVC];
                if (mode == ECPP_MODE_STD || mode == ECPP_MODE_BIDIR
                    || wdat_r[7:6] == 2'b00)
                    ectrl_r[7:5] <= wdat_r[7:5];
            end
            // Service event sets the disable bit; set wins over write
            if (svc_hit)
                ectrl_r[ECPP_ECR_SVC] <= 1'b1;
        end
    end

    // Channel configuration (irq/dma selection)
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            chcfg_r <= ECPP_CHCFG_RST;
        else if (w_chcfg)
            chcfg_r <= {wdat_r[5:3], 1'b0, wdat_r[1:0]};
    end

    ////////////////////////////////////////////////////////////////
    // Direction: forced out in 000/010; kept otherwise
    assign dir = (mode == ECPP_MODE_STD || mode == ECPP_MODE_CFIFO)
        ? 1'b0 : control_r[ECPP_CTL_DIR];
    assign direction_indicator = dir;
    // Standard and compat-fifo modes always drive
    assign drive_ok = (mode == ECPP_MODE_STD || mode == ECPP_MODE_CFIFO) || !dir;
    assign periph_data_lines_oe_n = !drive_ok;

    ////////////////////////////////////////////////////////////////
    // FIFO path: 9-bit entries, tag in bit 8; one byte per entry
    logic fifo_wr_ok;
    logic [8:0] f_in_data;
    assign fifo_wr_ok = (mode == ECPP_MODE_CFIFO || mode == ECPP_MODE_EXT
        || mode == ECPP_MODE_TEST);
    assign f_in_valid = (w_fifo && fifo_wr_ok)
        || (w_data && mode == ECPP_MODE_EXT);
    // Address writes tag low, data writes tag high
    assign f_in_data = {!(w_data && mode == ECPP_MODE_EXT), wdat_r};

    ecpp_fifo
    #(
        .WIDTH(9),
        .DEPTH(ECPP_FIFO_DEPTH)
    )
    u_fifo
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .flush(!fifo_mode),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data),
        .level(f_level)
    );

    // Full counts FIFO only; the transmit byte is extra
    assign full_flag = fifo_mode && !f_in_ready;
    assign empty_flag = !fifo_mode || !f_out_valid;

    ////////////////////////////////////////////////////////////////
    // Transmit stage: one byte loaded, strobed, acknowledged
    typedef enum logic [1:0]
    {
        ECPP_TX_IDLE = 2'b00,
        ECPP_TX_SETUP = 2'b01,
        ECPP_TX_STROBE = 2'b10,
        ECPP_TX_WAIT = 2'b11
    } ecpp_tx_type;
    ecpp_tx_type tx_r;

    // Byte leaves FIFO into transmit stage; no decompression
    assign f_out_ready = (tx_r == ECPP_TX_IDLE) && !dir
        && mode != ECPP_MODE_TEST;

    // Handshake engine timed by reference clock
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_r <= ECPP_TX_IDLE;
            pout_r <= 8'h00;
            strobe_r <= 1'b0;
            scnt_r <= 8'h00;
        end
        else
        begin
            case (tx_r)
                ECPP_TX_IDLE:
                begin
                    strobe_r <= 1'b0;
                    if (f_out_valid && f_out_ready)
                    begin
                        pout_r <= f_out_data[7:0];
                        tx_r <= ECPP_TX_SETUP;
                    end
                end
                ECPP_TX_SETUP:
                    // Wait for the peripheral to be ready
                    if (!busy_in)
                    begin
                        strobe_r <= 1'b1;
                        scnt_r <= 8'(ECPP_STROBE_CYC);
                        tx_r <= ECPP_TX_STROBE;
                    end
                ECPP_TX_STROBE:
                    if (scnt_r <= 8'h01)
                    begin
                        strobe_r <= 1'b0;
                        tx_r <= ECPP_TX_WAIT;
                    end
                    else
                        scnt_r <= scnt_r - 8'h01;
                ECPP_TX_WAIT:
                    // Byte done once busy drops or accept pulses
                    if (!busy_in || !accept_in_n)
                        tx_r <= ECPP_TX_IDLE;
                default:
                    tx_r <= ECPP_TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Peripheral outputs: data register in standard modes
    assign periph_data_lines_out = fifo_mode ? pout_r : data_r;
    assign strobe_out_n = !(control_r[ECPP_CTL_STROBE] || strobe_r);
    assign line_feed_out_n = !control_r[ECPP_CTL_LFEED];
    assign init_out_n = control_r[ECPP_CTL_INIT];
    assign select_out_n = !control_r[ECPP_CTL_SELECT];

    ////////////////////////////////////////////////////////////////
    // Service events: threshold for programmed I/O, TC for DMA
    logic thresh_ok;
    assign thresh_ok = dir ? (f_level >= 5'(ECPP_FIFO_THRESH))
        : (5'(ECPP_FIFO_DEPTH) - f_level >= 5'(ECPP_FIFO_THRESH));
    assign svc_hit = fifo_mode && !ectrl_r[ECPP_ECR_SVC]
        && (ectrl_r[ECPP_ECR_DMAEN] ? term_count : thresh_ok);

    // Service pulse and level acknowledge interrupt
    logic pulse_r;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pulse_r <= 1'b0;
        else
            pulse_r <= svc_hit;
    end
    assign ack_irq = control_r[ECPP_CTL_ACKIE] && !accept_in_n;
    assign irq_line_n = !(pulse_r || ack_irq);

    // Route to one line per channel config
    assign irq5_n = (chcfg_r[5:3] == 3'b111) ? irq_line_n : 1'b1;
    assign irq9_n = (chcfg_r[5:3] == 3'b010) ? irq_line_n : 1'b1;
    assign irq7_n = (chcfg_r[5:3] != 3'b111 && chcfg_r[5:3] != 3'b010)
        ? irq_line_n : 1'b1;
    assign irq_pulse_n = !pulse_r;

    // DMA request held until acknowledge
    logic [1:0] ch;
    assign ch = chcfg_r[1:0];
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            dma_act_r <= 1'b0;
        else
            dma_act_r <= fifo_mode && ectrl_r[ECPP_ECR_DMAEN]
                && !ectrl_r[ECPP_ECR_SVC] && f_in_ready && !dir;
    end
    assign dma_req[1] = dma_act_r && ch == 2'b01 && dma_ack_n[1];
    assign dma_req[2] = dma_act_r && ch == 2'b10 && dma_ack_n[2];
    assign dma_req[3] = dma_act_r && (ch == 2'b00 || ch == 2'b11) && dma_ack_n[3];

    ////////////////////////////////////////////////////////////////
    // Read mux; data read is pass-through of the pins
    always_comb
    begin
        host_dout = 8'h00;
        if (hit_data)
            host_dout = periph_data_lines_in;
        else if (!cs_n && addr == ECPP_OFS_STATUS)
            host_dout = {!busy_in, accept_in_n, media_absent_in, selected_in,
                fault_in_n, 3'b111};
        else if (hit_ctl)
            host_dout = {2'b00, dir, control_r[4], !select_out_n,
                init_out_n, !line_feed_out_n, !strobe_out_n};
        else if (hit_fifo && mode == ECPP_MODE_CFG)
            host_dout = ECPP_CAPCFG;
        else if (hit_fifo && (mode == ECPP_MODE_EXT || mode == ECPP_MODE_TEST))
            host_dout = f_out_data[7:0];
        else if (hit_chcfg)
            host_dout = {1'b1, !irq_line_n, chcfg_r};
        else if (hit_ectrl)
            host_dout = {ectrl_r[7:2], full_flag, empty_flag};
    end
    assign host_doe_n = !rd_act;

    ////////////////////////////////////////////////////////////////
    // Checks
    // Cycles from the second strobe cycle to the first idle one
    localparam int STB_END = ECPP_STROBE_CYC - 1;

    mode_after_reset_a: assert property (@(posedge clk_sys)
        $rose(rst_n) |-> mode == ECPP_MODE_STD && !dir)
        else $error("mode not standard after reset");
    dir_indicator_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        direction_indicator == dir && (!dir || periph_data_lines_oe_n))
        else $error("direction indicator mismatch");
    std_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == ECPP_MODE_STD || mode == ECPP_MODE_CFIFO)
        |-> !periph_data_lines_oe_n && !dir)
        else $error("data lines not driven in output mode");
    data_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (w_data && mode == ECPP_MODE_STD) |=> data_r == $past(wdat_r))
        else $error("data register missed write");
    data_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!w_data && mode == ECPP_MODE_STD) |=> $stable(data_r))
        else $error("data register changed without write");
    mode_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (mode == ECPP_MODE_ENH && w_ectrl && wdat_r[7:6] != 2'b00)
        |=> mode == ECPP_MODE_ENH)
        else $error("mode changed illegally");
    strobe_width_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(strobe_r) |-> strobe_r [*2] ##[STB_END:STB_END] !strobe_r)
        else $error("strobe width wrong");
    data_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        hit_data |-> host_dout == periph_data_lines_in)
        else $error("data read not pass-through");
    svc_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        svc_hit |=> ectrl_r[ECPP_ECR_SVC] && !irq_pulse_n ##1 irq_pulse_n)
        else $error("service interrupt not single pulse");
    chcfg_guard_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_pulse && mode != ECPP_MODE_CFG) |=> $stable(chcfg_r))
        else $error("channel config written outside mode");

    fifo_send_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        mode == ECPP_MODE_CFIFO && $rose(strobe_r));
    fifo_full_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        full_flag);
    bidir_in_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(direction_indicator));
    enh_mode_c: cover property (@(posedge clk_sys) disable iff (!rst_n)
        mode == ECPP_MODE_ENH);

endmodule

`default_nettype wire

// ---- design/ecpp_pkg.sv ----
package ecpp_pkg;

    // Register offsets, low bank and high bank (A10 set)
    localparam logic [10:0] ECPP_OFS_DATA = 11'h000;
    localparam logic [10:0] ECPP_OFS_STATUS = 11'h001;
    localparam logic [10:0] ECPP_OFS_CONTROL = 11'h002;
    localparam logic [10:0] ECPP_OFS_EADDR = 11'h003;
    localparam logic [10:0] ECPP_OFS_EDATA = 11'h004;
    localparam logic [10:0] ECPP_OFS_FIFO = 11'h400;
    localparam logic [10:0] ECPP_OFS_CHCFG = 11'h401;
    localparam logic [10:0] ECPP_OFS_ECTRL = 11'h402;

    // Control register fields
    localparam int ECPP_CTL_STROBE = 0;
    localparam int ECPP_CTL_LFEED = 1;
    localparam int ECPP_CTL_INIT = 2;
    localparam int ECPP_CTL_SELECT = 3;
    localparam int ECPP_CTL_ACKIE = 4;
    localparam int ECPP_CTL_DIR = 5;

    // Extended control fields
    localparam int ECPP_ECR_EMPTY = 0;
    localparam int ECPP_ECR_FULL = 1;
    localparam int ECPP_ECR_SVC = 2;
    localparam int ECPP_ECR_DMAEN = 3;
    localparam int ECPP_ECR_ERRIE = 4;
    localparam int ECPP_ECR_MODE_LO = 5;

    // Reset values
    // Standard mode, service and error interrupts off, FIFO empty
    localparam logic [7:0] ECPP_ECTRL_RST = 8'h15;
    localparam logic [7:0] ECPP_CONTROL_RST = 8'h04;
    localparam logic [5:0] ECPP_CHCFG_RST = 6'h0B;

    // Capability register: one-byte words, spare transmit byte, pulsed irqs
    localparam logic [7:0] ECPP_CAPCFG = 8'h94;

    // Fixed depth, service threshold, word size
    localparam int ECPP_FIFO_DEPTH = 16;
    localparam int ECPP_FIFO_THRESH = 8;
    localparam int ECPP_WORD_BYTES = 1;

    // Reference clock and strobe timing
    localparam int ECPP_CLK_HZ = 40000000;
    localparam int ECPP_STROBE_NS = 500;
    localparam int ECPP_STROBE_CYC = (ECPP_STROBE_NS * (ECPP_CLK_HZ / 1000000) + 999) / 1000;

    // Port modes from extended control bits 7:5
    typedef enum logic [2:0]
    {
        ECPP_MODE_STD = 3'b000,
        ECPP_MODE_BIDIR = 3'b001,
        ECPP_MODE_CFIFO = 3'b010,
        ECPP_MODE_EXT = 3'b011,
        ECPP_MODE_ENH = 3'b100,
        ECPP_MODE_RSVD = 3'b101,
        ECPP_MODE_TEST = 3'b110,
        ECPP_MODE_CFG = 3'b111
    } ecpp_mode_type;

endpackage

// ---- design/ecpp_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none

module ecpp_fifo
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Level
    output logic [$clog2(DEPTH):0] level
);

    localparam int AW = $clog2(DEPTH);

    // Storage array
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != '0);
    assign out_data = mem_r[rd_ptr_r];
    assign level = count_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    ////////////////////////////////////////////////////////////////
    // Write into the array
    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem_r[wr_ptr_r] <= in_data;
    end

    // Pointers and occupancy; flush drops everything
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else if (flush)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end

endmodule

`default_nettype wire

// ---- design/ecpp_sync_edge.sv ----
`timescale 1ns/10ps
`default_nettype none

module ecpp_sync_edge
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Strobe in, active low
    input wire logic strobe_n,
    // Trailing-edge pulse
    output logic rise
);

    // Previous strobe level
    logic prev_r;

    ////////////////////////////////////////////////////////////////
    // Strobe is synchronous, so a single stage finds the rising edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            prev_r <= 1'b1;
        else
            prev_r <= strobe_n;
    end

    assign rise = strobe_n && !prev_r;

endmodule

`default_nettype wire

// ---- verification/ecpp_printer_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ecpp_printer_model
(
    // Data lines
    input wire logic [7:0] periph_data_lines_in,
    output logic [7:0] drive_data,
    // Handshake
    input wire logic strobe_out_n,
    input wire logic stall,
    output logic busy_in,
    output logic accept_in_n,
    // Status
    output logic fault_in_n,
    output logic selected_in,
    output logic media_absent_in
);
    logic [7:0] taken[$];
    logic printing = 1'h0;
    // Busy while printing or stalled
    assign busy_in = stall | printing;
    assign {fault_in_n, selected_in, media_absent_in} = 3'h6;
    assign drive_data = 8'hA5;
    // Take byte at strobe, accept later
    initial
    begin
        accept_in_n = 1'h1;
        forever
        begin
            @(negedge strobe_out_n);
            taken.push_back(periph_data_lines_in);
            printing = 1'h1;
            #300 accept_in_n = 1'h0;
            #100 accept_in_n = 1'h1;
            printing = 1'h0;
        end
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ecpp_pkg::*;
    // Host bus
    logic clk_sys, rst_n, cs_n, ior_n, iow_n, host_doe_n, irq5_n, irq7_n, irq9_n, term_count;
    logic [10:0] addr;
    logic [3:1] dma_req, dma_ack_n;
    logic [7:0] host_din, host_dout, got, b, pins;
    // Printer side
    logic [7:0] periph_data_lines_out, drive_data;
    logic periph_data_lines_oe_n, strobe_out_n, line_feed_out_n, init_out_n, select_out_n, stall;
    logic fault_in_n, selected_in, busy_in, accept_in_n, media_absent_in, direction_indicator;
    wire logic [7:0] periph_data_lines_in;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 32'h6546;
    int sent[$];
    // Port drives while enable low
    assign periph_data_lines_in = periph_data_lines_oe_n ? drive_data : periph_data_lines_out;
    assign pins = {2'h0, strobe_out_n, line_feed_out_n, init_out_n, select_out_n,
        direction_indicator, periph_data_lines_oe_n};
    ecpp_core DUT
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .ior_n(ior_n), .iow_n(iow_n),
        .addr(addr), .host_din(host_din), .host_dout(host_dout), .host_doe_n(host_doe_n),
        .irq5_n(irq5_n), .irq7_n(irq7_n), .irq9_n(irq9_n), .dma_req(dma_req),
        .dma_ack_n(dma_ack_n), .term_count(term_count),
        .periph_data_lines_in(periph_data_lines_in),
        .periph_data_lines_out(periph_data_lines_out),
        .periph_data_lines_oe_n(periph_data_lines_oe_n), .strobe_out_n(strobe_out_n),
        .line_feed_out_n(line_feed_out_n), .init_out_n(init_out_n),
        .select_out_n(select_out_n), .fault_in_n(fault_in_n), .selected_in(selected_in),
        .busy_in(busy_in), .accept_in_n(accept_in_n), .media_absent_in(media_absent_in),
        .direction_indicator(direction_indicator)
    );
    ecpp_printer_model P
    (
        .periph_data_lines_in(periph_data_lines_in), .drive_data(drive_data),
        .strobe_out_n(strobe_out_n), .stall(stall), .busy_in(busy_in),
        .accept_in_n(accept_in_n), .fault_in_n(fault_in_n), .selected_in(selected_in),
        .media_absent_in(media_absent_in)
    );
    initial
    begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        samples_checked++;
        num_errors += int'(seen !== exp);
        if (seen !== exp)
            $display("mismatch %s expected %h seen %h", what, exp, seen);
    endtask
    // Host cycle; writes commit as the strobe rises, reads taken mid-cycle
    task automatic bus(input logic w, input logic [10:0] a, input logic [7:0] d);
        {cs_n, iow_n, ior_n} <= {1'h0, ~w, w};
        {addr, host_din} <= {a, d};
        @(posedge clk_sys);
        iow_n <= 1'h1;
        @(negedge clk_sys);
        got = host_dout;
        @(posedge clk_sys);
        {cs_n, ior_n} <= 2'h3;
        @(posedge clk_sys);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        #200000 num_errors++;
        conclude();
    end
    initial
    begin
        {rst_n, cs_n, ior_n, iow_n, stall, term_count, dma_ack_n} = 9'h0E7;
        {addr, host_din} = 19'h0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        chk("rst_pins", 8'h3C, pins);
        // Data and control pins
        b = 8'($random(seed));
        bus(1'h1, ECPP_OFS_DATA, b);
        chk("data_out", b, periph_data_lines_out);
        bus(1'h1, ECPP_OFS_CONTROL, 8'h0A);
        chk("ctl_pins", 8'h20, pins);
        $display("test data done");
        // Turnaround and forcing
        bus(1'h1, ECPP_OFS_ECTRL, 8'h35);
        bus(1'h1, ECPP_OFS_CONTROL, 8'h24);
        chk("dir_in", 8'h3F, pins);
        bus(1'h0, ECPP_OFS_DATA, 8'h00);
        chk("pin_read", 8'hA5, got);
        bus(1'h1, ECPP_OFS_ECTRL, 8'h55);
        chk("dir_out", 8'h3C, pins);
        bus(1'h1, ECPP_OFS_DATA, 8'h3C);
        bus(1'h1, ECPP_OFS_ECTRL, 8'h35);
        chk("kept", b, periph_data_lines_out);
        bus(1'h1, ECPP_OFS_ECTRL, 8'h55);
        $display("test dir done");
        // Fill while stalled, then drain
        stall <= 1'h1;
        for (int i = 1; i <= 18; i++)
        begin
            b = 8'($random(seed));
            bus(1'h1, ECPP_OFS_FIFO, b);
            if (i <= 17)
                sent.push_back(b);
            bus(1'h0, ECPP_OFS_ECTRL, 8'h00);
            chk("full", {7'h0, i >= 17}, {7'h0, got[ECPP_ECR_FULL]});
        end
        stall <= 1'h0;
        for (int t = 0; t < 2000 && P.taken.size() < 17; t++)
            @(posedge clk_sys);
        chk("count", 8'd17, 8'(P.taken.size()));
        foreach (sent[k])
            chk("byte", 8'(sent[k]), P.taken[k]);
        $display("test fifo done");
        // Service request on an empty FIFO: one pulse on the default line
        bus(1'h1, ECPP_OFS_ECTRL, 8'h51);
        @(negedge clk_sys);
        chk("svc_irq", 8'h05, {5'h0, irq5_n, irq7_n, irq9_n});
        @(posedge clk_sys);
        bus(1'h0, ECPP_OFS_ECTRL, 8'h00);
        chk("svc_bit", 8'h55, got);
        $display("test svc done");
        // Capability byte in mode 111
        bus(1'h1, ECPP_OFS_ECTRL, 8'h15);
        bus(1'h1, ECPP_OFS_ECTRL, 8'hF5);
        bus(1'h0, ECPP_OFS_FIFO, 8'h00);
        chk("capcfg", ECPP_CAPCFG, got);
        $display("test cap done");
        conclude();
    end
endmodule
`default_nettype wire
